// [sfi_map.vh]
// Register map, field positions, reset values and constants of the
// serial flash interface. Assumes a 32-bit APB slave with word registers.
// Summary of operation
// [RQ1] Read mode selects register or mapped window reads
// [RQ2] Mapped mode serializes reads, deserializes returned data
// [RQ3] Dummy write in register mode returns read byte
// [RQ4] Written byte latched for sending, empty flag set
// [RQ5] Output enable low leaves data pin undriven
// [RQ6] Output enable high drives the data pin
// [RQ7] Software always writes reserved config bit six one
// [RQ8] Serial clock derived from external memory clock
// [RQ9] Divide code selects ratio two through nine
// [RQ10] Odd ratios give unequal clock high/low
// [RQ11] Polarity bit sets serial clock idle level
// [RQ12] Phase equal polarity: rising edge data, else falling
// [RQ13] Enable low keeps interface disabled, window unused
// [RQ14] Ready flag set on byte, cleared on read
// [RQ15] Overrun when loading while ready; read clears it
// [RQ16] Select bit drives select pin, register mode only
// [RQ17] Busy flag high during serial transfer
// [RQ18] Mapped mode ignores flash writes
`ifndef SFI_MAP_VH
`define SFI_MAP_VH
// Printed offsets are not all multiples of four: indices, byte addr = 4*idx
`define SFI_IDX_READ      12'hB00
`define SFI_IDX_WRITE     12'hB02
`define SFI_IDX_CONFIG    12'hB04
`define SFI_IDX_FLAGS     12'hB06
`define SFI_IDX_SELECT    12'hB0A
`define SFI_IDX_DRIVE     12'hB0C
`define SFI_IDX_MAPADDR   12'hB10
`define SFI_IDX_MAPDATA   12'hB12
`define SFI_WINDOW_BASE   32'h2000_0000
// Configuration fields
`define SFI_CFG_ENABLE    0
`define SFI_CFG_CPOL      1
`define SFI_CFG_CPHA      2
`define SFI_CFG_DIV_LO    3
`define SFI_CFG_RSVD      6
`define SFI_CFG_MODE      7
// Flag fields
`define SFI_FLG_READY     0
`define SFI_FLG_OVERRUN   1
`define SFI_FLG_EMPTY     2
`define SFI_FLG_BUSY      3
// Reset values
`define SFI_RST_READ      8'hFF
`define SFI_RST_WRITE     8'h00
`define SFI_RST_CONFIG    8'h11
`define SFI_RST_FLAGS     8'h04
`define SFI_RST_SELECT    8'h00
`define SFI_RST_DRIVE     8'h00
// Serial flash read command and mapped read length
`define SFI_CMD_READ      8'h03
`define SFI_MAP_BYTES     8'h04
`endif

// [sfi_fifo.v]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-low reset.
module sfi_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             sys_clk_in,
    input  wire             rst_n_in,
    // Fill side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // Drain side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready_out  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign out_data_out  = mem[rd_q];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;

    // Storage has no reset; only pointers need defined state
    always @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_q] <= in_data_in;
        end
    end

    // Pointers wrap naturally since DEPTH is a power of two
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // sfi_fifo

// [sfi_top.v]
// Serial flash interface: APB registers, serial engine, mapped reads.
// Assumes APB master on sys_clk_in; external memory clock is sampled
// synchronously, as are all pins.
`include "sfi_map.vh"
module sfi_top #(
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW    = 5
) (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // External memory clock, source of the serial clock
    input  wire        sdram_clk_in,
    // Serial flash pins
    output reg         flash_serial_clock_out,
    output reg         flash_select_n_out,
    input  wire        flash_data_line_in,
    output reg         flash_data_line_out,
    output reg         flash_data_line_oe_n_out,
    // Mapped read stream
    output wire        map_valid_out,
    input  wire        map_ready_in,
    output wire [7:0]  map_data_out
);
    // Register state
    reg [7:0]  rd_byte_q;
    reg [7:0]  wr_byte_q;
    reg [7:0]  cfg_q;
    reg        ready_q;
    reg        overrun_q;
    reg        empty_q;
    reg        sel_q;
    reg        drive_q;
    reg [23:0] map_addr_q;
    // Serial engine
    reg [7:0]  shift_q;
    reg [7:0]  rx_q;
    reg [3:0]  bit_q;
    reg [3:0]  div_q;
    reg        half_q;
    reg        sck_q;
    reg        clk_s1_q;
    reg        clk_s2_q;
    reg        clk_s3_q;
    reg [2:0]  state_q;
    reg [2:0]  mbyte_q;
    reg [7:0]  mleft_q;
    reg        mstart_q;

    localparam ST_IDLE = 3'd0;
    localparam ST_LEAD = 3'd1;
    localparam ST_TRAIL = 3'd2;
    localparam ST_DONE = 3'd3;

    wire        fifo_ready;
    wire        mode_map = cfg_q[`SFI_CFG_MODE];
    wire        enable   = cfg_q[`SFI_CFG_ENABLE];
    wire        cpol     = cfg_q[`SFI_CFG_CPOL];
    wire        cpha     = cfg_q[`SFI_CFG_CPHA];
    wire [2:0]  div_code = cfg_q[`SFI_CFG_DIV_LO+2:`SFI_CFG_DIV_LO];
    wire [3:0]  div_n    = {1'b0, div_code} + 4'd2; // RQ9
    wire        busy     = (state_q != ST_IDLE);
    wire        wr_acc   = psel & penable & pwrite;
    wire        rd_acc   = psel & penable & ~pwrite;
    wire [11:0] idx      = paddr[13:2];
    wire        mapped   = (paddr[13:0] == {idx, 2'b00}) & (paddr[31:14] == 18'd0);
    wire        sck_tick;

    // Word decode used by read and write paths
    function hit;
        input [11:0] a;
        input [11:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(mapped & (hit(idx, `SFI_IDX_READ)
                   | hit(idx, `SFI_IDX_WRITE) | hit(idx, `SFI_IDX_CONFIG)
                   | hit(idx, `SFI_IDX_FLAGS) | hit(idx, `SFI_IDX_SELECT)
                   | hit(idx, `SFI_IDX_DRIVE) | hit(idx, `SFI_IDX_MAPADDR)
                   | hit(idx, `SFI_IDX_MAPDATA)));

    // Memory clock rising edges advance the divider; three flops so the
    // edge detector never looks at the first synchroniser stage
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
        end else begin
            clk_s1_q <= sdram_clk_in;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
        end
    end
    assign sck_tick = clk_s2_q & ~clk_s3_q; // RQ8

    // Register writes; a byte write starts a transfer in register mode
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wr_byte_q  <= `SFI_RST_WRITE;
            cfg_q      <= `SFI_RST_CONFIG;
            sel_q      <= 1'b0;
            drive_q    <= 1'b0;
            map_addr_q <= 24'h000000;
            mstart_q   <= 1'b0;
        end else begin
            mstart_q <= 1'b0;
            if (wr_acc & mapped) begin
                if (hit(idx, `SFI_IDX_CONFIG)) begin
                    cfg_q <= pwdata[7:0];
                end
                if (hit(idx, `SFI_IDX_SELECT)) begin
                    sel_q <= pwdata[0];
                end
                if (hit(idx, `SFI_IDX_DRIVE)) begin
                    drive_q <= pwdata[0];
                end
                if (hit(idx, `SFI_IDX_MAPADDR)) begin
                    map_addr_q <= pwdata[23:0];
                    mstart_q   <= enable & mode_map & ~busy; // RQ13
                end
                // Mapped mode owns the engine; byte writes are dropped
                if (hit(idx, `SFI_IDX_WRITE) & ~mode_map & enable) begin // RQ18
                    wr_byte_q <= pwdata[7:0]; // RQ3
                end
            end
        end
    end

    wire wr_start = wr_acc & mapped & hit(idx, `SFI_IDX_WRITE)
                  & ~mode_map & enable & ~busy;

    // Serial engine: each bit is a leading then trailing half period
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            rx_q    <= 8'h00;
            bit_q   <= 4'd0;
            div_q   <= 4'd0;
            half_q  <= 1'b0;
            sck_q   <= 1'b0;
            mbyte_q <= 3'd0;
            mleft_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sck_q <= cpol; // RQ11
                    div_q <= 4'd0;
                    bit_q <= 4'd0;
                    if (wr_start) begin
                        shift_q <= pwdata[7:0]; // RQ4
                        mleft_q <= 8'h00;
                        state_q <= ST_LEAD;
                    end else if (mstart_q) begin
                        shift_q <= `SFI_CMD_READ; // RQ2
                        mbyte_q <= 3'd1;
                        mleft_q <= `SFI_MAP_BYTES;
                        state_q <= ST_LEAD;
                    end
                end
                ST_LEAD, ST_TRAIL: begin
                    if (sck_tick) begin
                        if (div_q == div_n - 4'd1) begin
                            div_q <= 4'd0;
                        end else begin
                            div_q <= div_q + 4'd1;
                        end
                        // Leading (idle-level) half is the shorter one on odd ratios
                        if (div_q == (div_n >> 1) - 4'd1) begin // RQ10
                            sck_q <= ~sck_q;
                            // Phase 0 samples here; phase 1 shifts, except on the first bit
                            if (!cpha) begin // RQ12
                                rx_q <= {rx_q[6:0], flash_data_line_in};
                            end else if (bit_q != 4'd0) begin
                                shift_q <= {shift_q[6:0], 1'b0};
                            end
                        end
                        if (div_q == div_n - 4'd1) begin
                            sck_q <= ~sck_q;
                            if (!cpha) begin
                                shift_q <= {shift_q[6:0], 1'b0};
                            end else begin
                                rx_q <= {rx_q[6:0], flash_data_line_in};
                            end
                            bit_q <= bit_q + 4'd1;
                            if (bit_q == 4'd7) begin
                                state_q <= ST_DONE;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    bit_q <= 4'd0;
                    // Command, three address bytes, data; last waits room
                    if (mleft_q != 8'h00 && fifo_ready) begin
                        state_q <= ST_LEAD;
                        if (mbyte_q < 3'd4) begin
                            mbyte_q <= mbyte_q + 3'd1;
                            case (mbyte_q)
                                3'd1: shift_q <= map_addr_q[23:16];
                                3'd2: shift_q <= map_addr_q[15:8];
                                3'd3: shift_q <= map_addr_q[7:0];
                                default: shift_q <= 8'h00;
                            endcase
                        end else begin
                            mleft_q <= mleft_q - 8'd1;
                            shift_q <= 8'h00;
                        end
                    end else if (~|mleft_q & (fifo_ready | ~mode_map)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    wire rx_done = (state_q == ST_DONE);
    wire map_push = rx_done & mode_map & (mbyte_q == 3'd4)
                  & (mleft_q != `SFI_MAP_BYTES) & fifo_ready;
    wire reg_load = rx_done & ~mode_map;

    // Received bytes and flags; a set beats a same-cycle clear
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rd_byte_q <= `SFI_RST_READ;
            ready_q   <= 1'b0;
            overrun_q <= 1'b0;
            empty_q   <= 1'b1;
        end else begin
            if (rd_acc & mapped & hit(idx, `SFI_IDX_READ)) begin
                ready_q   <= 1'b0; // RQ14
                overrun_q <= 1'b0; // RQ15
            end
            if (reg_load) begin
                rd_byte_q <= rx_q; // RQ1
                ready_q   <= 1'b1; // RQ14
                if (ready_q) begin
                    overrun_q <= 1'b1; // RQ15
                end
            end
            if (wr_start) begin
                empty_q <= 1'b0;
            end else if (state_q == ST_LEAD && bit_q == 4'd0) begin
                empty_q <= 1'b1; // RQ4
            end
        end
    end

    // Pins: select from control bit only in register mode
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            flash_serial_clock_out   <= 1'b0;
            flash_select_n_out       <= 1'b1;
            flash_data_line_out      <= 1'b0;
            flash_data_line_oe_n_out <= 1'b1;
        end else begin
            flash_serial_clock_out <= enable ? sck_q : cpol; // RQ13
            if (!enable) begin
                flash_select_n_out <= 1'b1; // RQ13
            end else if (mode_map) begin
                flash_select_n_out <= ~busy;
            end else begin
                flash_select_n_out <= ~sel_q; // RQ16
            end
            flash_data_line_out <= shift_q[7];
            if (mode_map) begin
                flash_data_line_oe_n_out <= ~(busy & (mbyte_q < 3'd4 |
                                              mleft_q == `SFI_MAP_BYTES));
            end else begin
                flash_data_line_oe_n_out <= ~(drive_q & enable); // RQ5 RQ6
            end
        end
    end

    // Mapped bytes queue up; a full queue stalls the engine
    sfi_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (map_push),
        .in_ready_out  (fifo_ready),
        .in_data_in    (rx_q),
        .out_valid_out (map_valid_out),
        .out_ready_in  (map_ready_in | (rd_acc & mapped &
                        hit(idx, `SFI_IDX_MAPDATA))),
        .out_data_out  (map_data_out)
    );

    // Read mux
    always @* begin
        prdata = 32'h0000_0000;
        if (mapped) begin
            if (hit(idx, `SFI_IDX_READ)) prdata[7:0] = rd_byte_q;
            if (hit(idx, `SFI_IDX_CONFIG)) prdata[7:0] = cfg_q;
            if (hit(idx, `SFI_IDX_FLAGS)) prdata[3:0] =
                {busy, empty_q, overrun_q, ready_q}; // RQ17
            if (hit(idx, `SFI_IDX_SELECT)) prdata[0] = sel_q;
            if (hit(idx, `SFI_IDX_DRIVE)) prdata[0] = drive_q;
            if (hit(idx, `SFI_IDX_MAPADDR)) prdata[23:0] = map_addr_q;
            if (hit(idx, `SFI_IDX_MAPDATA)) prdata[8:0] =
                {map_valid_out, map_data_out & {8{map_valid_out}}};
        end
    end
endmodule // sfi_top

// [sfi_top_properties.sv]
// Checker for the serial flash interface, bound to sfi_top.
// Assumes registers change only through APB word writes.
`include "sfi_map.vh"
module sfi_chk (
    // Clock and reset
    input logic        sys_clk_in,
    input logic        rst_n_in,
    // Register bus
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    // Memory clock and flash pins
    input logic        sdram_clk_in,
    input logic        flash_serial_clock_out,
    input logic        flash_select_n_out,
    input logic        flash_data_line_oe_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  cfg_q;
    logic [3:0]  quiet_q, rises_q, since_q;
    logic        drv_q, sel_q, s1_q, s2_q, seen_q;
    wire         wr_w = psel && penable && pwrite;
    wire         up_w = s1_q && !s2_q;
    wire  [11:0] idx_w = paddr[13:2];

    // Shadow control registers; quiet_q lets pins settle after a write
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cfg_q <= 8'h11;
            drv_q <= 1'b0;
            sel_q <= 1'b0;
            quiet_q <= 4'h0;
        end else begin
            if (wr_w && idx_w == `SFI_IDX_CONFIG) cfg_q <= pwdata[7:0];
            if (wr_w && idx_w == `SFI_IDX_DRIVE) drv_q <= pwdata[0];
            if (wr_w && idx_w == `SFI_IDX_SELECT) sel_q <= pwdata[0];
            quiet_q <= wr_w ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
        end
    end
    // Memory clock rises per serial period; counts saturate on long gaps
    always @(posedge sys_clk_in) begin
        s1_q <= sdram_clk_in;
        s2_q <= s1_q;
        if (!rst_n_in) begin
            rises_q <= 4'hF;
            since_q <= 4'hF;
            seen_q <= 1'b0;
        end else begin
            since_q <= up_w ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
            if ($rose(flash_serial_clock_out)) begin
                rises_q <= 4'h0;
                seen_q <= !flash_select_n_out;
            end else begin
                rises_q <= rises_q + {3'h0, up_w && rises_q != 4'hF};
                if (flash_select_n_out || wr_w) seen_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Register mode, enabled, settled since the last write
    sequence s_reg;
        quiet_q > 4'h3 && cfg_q[0] && !cfg_q[7];
    endsequence
    // Deselected and settled for several cycles
    sequence s_idle;
        (flash_select_n_out && quiet_q > 4'h3) [*4];
    endsequence

    AST_OE_RELEASE: assert property (s_reg ##0 !drv_q |->
        flash_data_line_oe_n_out) else $error("data line driven");
    AST_OE_DRIVE: assert property (s_reg ##0 drv_q |->
        !flash_data_line_oe_n_out) else $error("data line not driven");
    AST_SEL_FOLLOW: assert property (s_reg |->
        flash_select_n_out == !sel_q) else $error("select pin mismatch");
    AST_IDLE_LEVEL: assert property (s_idle |->
        flash_serial_clock_out == cfg_q[1]) else $error("bad idle level");
    AST_DIV_RATIO: assert property ($rose(flash_serial_clock_out)
        && seen_q && rises_q < 4'hA |-> rises_q == cfg_q[5:3] + 4'h2)
        else $error("serial clock period wrong");
    AST_DIV_SOURCE: assert property (quiet_q > 4'h3 &&
        $changed(flash_serial_clock_out) |-> since_q < 4'h7)
        else $error("serial clock edge without memory clock");
    AST_OFF_STILL: assert property (quiet_q > 4'h3 && !cfg_q[0]
        |-> $stable(flash_serial_clock_out)) else $error("clock moves");
    AST_OVR_READY: assert property (psel && penable && !pwrite &&
        idx_w == `SFI_IDX_FLAGS |-> !prdata[1] || prdata[0])
        else $error("overrun without ready");
endmodule // sfi_chk

bind sfi_top sfi_chk sfi_chk_i (.sys_clk_in, .rst_n_in, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .sdram_clk_in,
    .flash_serial_clock_out, .flash_select_n_out, .flash_data_line_oe_n_out);

// [sfi_flash_model.sv]
// Behavioural serial flash answering the 0x03 read with a fixed pattern.
// Assumes the bench resolves the shared data line.
module sfi_flash_model (
    // Serial pins
    input  wire logic       sck_in,
    input  wire logic       sel_n_in,
    input  wire logic       dq_in,
    // Clock mode as programmed
    input  wire logic       cpol_in,
    input  wire logic       cpha_in,
    // Line driven back and last byte heard
    output logic            dq_out,
    output logic [7:0]      rx_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int          n = 0;
    logic [31:0] cmd = 32'h0;
    logic [7:0]  d;

    // Byte stored at an address
    function automatic logic [7:0] fm(input logic [23:0] x);
        return x[7:0] ^ 8'h5A;
    endfunction
    // Sample on the valid edge, launch on the other
    always @(posedge sck_in or negedge sck_in or posedge sel_n_in) begin
        if (sel_n_in) begin
            n = 0;
            dq_out = ~dq_out; // Deselect inverts the last bit rather than releasing the line
        end else if (sck_in == (cpol_in == cpha_in)) begin
            if (n < 32) cmd = {cmd[30:0], dq_in};
            rx_out = {rx_out[6:0], dq_in};
            n++;
        end else if (n >= 32) begin
            d = cmd[31:24] == 8'h03 ? fm(cmd[23:0] + 24'((n - 32) / 8))
                                    : 8'hFF;
            dq_out = d[7 - (n % 8)];
        end
    end
endmodule // sfi_flash_model

// [tb.sv]
// Self-checking bench: APB master, flash model, stream sink.
// Assumes sfi_top, sfi_fifo and sfi_flash_model are compiled first.
`include "sfi_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk_in, rst_n_in, psel, penable, pwrite, sdram_clk_in;
    logic        map_ready_in, e, m_cpol, m_cpha;
    logic [31:0] paddr, pwdata, v, c;
    logic [23:0] a;
    logic [7:0]  b, q[$];
    wire  [31:0] prdata;
    wire  [7:0]  m_data, rx;
    wire         pready, pslverr, sck, sel_n, dq_o, oe_n, dq_p, m_valid;
    wire         dq = oe_n ? dq_p : dq_o;
    int          n_mismatch = 0, n_tests = 0, rcnt = 0, base = 0, per = 0;
    int          i, k, m_rdy, m_ovr;
    integer      seed;

    sfi_top sfi_top_i (.sys_clk_in, .rst_n_in, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sdram_clk_in,
        .flash_serial_clock_out(sck), .flash_select_n_out(sel_n),
        .flash_data_line_in(dq), .flash_data_line_out(dq_o),
        .flash_data_line_oe_n_out(oe_n), .map_valid_out(m_valid),
        .map_ready_in, .map_data_out(m_data));
    sfi_flash_model sfi_flash_model_i (.sck_in(sck), .sel_n_in(sel_n),
        .dq_in(dq), .cpol_in(m_cpol), .cpha_in(m_cpha), .dq_out(dq_p),
        .rx_out(rx));

    // System clock and a slower memory clock of its own phase
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        sdram_clk_in = 1'b0;
        #3;
        forever #50 sdram_clk_in = ~sdram_clk_in;
    end
    // Memory clock rises between serial clock rises
    always @(posedge sdram_clk_in) rcnt++;
    always @(posedge sck) begin
        per = rcnt - base;
        base = rcnt;
    end

    // Byte stored by the flash model at an address
    function automatic logic [7:0] fm(input logic [23:0] x);
        return x[7:0] ^ 8'h5A;
    endfunction
    // One APB transfer; result lands in v and e
    task automatic apb(input logic w, input logic [11:0] x,
                       input logic [31:0] d);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {18'h0, x, 2'b00};
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        @(posedge sys_clk_in);
        while (pready !== 1'b1) @(posedge sys_clk_in);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] x);
        apb(1'b0, x, 32'h0);
    endtask
    task automatic wr(input logic [11:0] x, input logic [31:0] d);
        apb(1'b1, x, d);
    endtask
    // Poll until the engine is idle, then take the flags once more
    task automatic idle;
        rd(`SFI_IDX_FLAGS);
        while (v[`SFI_FLG_BUSY]) rd(`SFI_IDX_FLAGS);
        rd(`SFI_IDX_FLAGS);
    endtask
    task automatic settle;
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic chk_val(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic chk_pin(input logic g, input logic x);
        chk_val({31'h0, g}, {31'h0, x});
    endtask
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #1ms;
        n_mismatch++;
        summarize;
    end

    // Main sequence
    initial begin
        seed = 32'h9978;
        {rst_n_in, psel, penable, pwrite, map_ready_in} = 5'h0;
        {paddr, pwdata, m_cpol, m_cpha} = 66'h0;
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        settle;
        chk_pin(sel_n, 1'b1);
        chk_pin(oe_n, 1'b1);
        rd(`SFI_IDX_READ);
        chk_val(v, 32'hFF);
        rd(`SFI_IDX_CONFIG);
        chk_val(v, 32'h11);
        rd(`SFI_IDX_FLAGS);
        chk_val(v, 32'h04);
        rd(12'hB08);
        chk_val({v[30:0], e}, 32'h1);
        // Every divide code, all four clock modes, random bytes out
        for (i = 0; i < 8; i++) begin
            m_cpol = i[0];
            m_cpha = i[1];
            wr(`SFI_IDX_CONFIG, 32'(32'h41 | (i << 3) | (i % 4 << 1)));
            wr(`SFI_IDX_SELECT, 32'h1);
            wr(`SFI_IDX_DRIVE, 32'h1);
            settle;
            chk_pin(sel_n, 1'b0);
            chk_pin(oe_n, 1'b0);
            b = 8'($random(seed));
            wr(`SFI_IDX_WRITE, {24'h0, b});
            rd(`SFI_IDX_FLAGS);
            chk_val(v & 32'h8, 32'h8);
            idle;
            chk_val({24'h0, rx}, {24'h0, b});
            chk_val(32'(per), 32'(i + 2));
            chk_val(v & 32'hC, 32'h4);
            wr(`SFI_IDX_SELECT, 32'h0);
            settle;
            chk_pin(sck, m_cpol);
        end
        // Register-mode read; the second byte overruns the first
        {m_cpol, m_cpha} = 2'b00;
        wr(`SFI_IDX_CONFIG, 32'h41);
        wr(`SFI_IDX_SELECT, 32'h1);
        a = 24'($random(seed));
        c = {8'h03, a};
        for (k = 0; k < 4; k++) begin
            wr(`SFI_IDX_WRITE, {24'h0, c[31 - 8 * k -: 8]});
            idle;
        end
        wr(`SFI_IDX_DRIVE, 32'h0);
        settle;
        chk_pin(oe_n, 1'b1);
        rd(`SFI_IDX_READ);
        m_rdy = 0;
        m_ovr = 0;
        for (k = 0; k < 2; k++) begin
            wr(`SFI_IDX_WRITE, 32'hFF);
            idle;
            m_ovr = m_rdy;
            m_rdy = 1;
            chk_val(v & 32'h3, 32'(m_ovr * 2 + m_rdy));
        end
        rd(`SFI_IDX_READ);
        chk_val(v & 32'hFF, {24'h0, fm(a + 24'h1)});
        rd(`SFI_IDX_FLAGS);
        chk_val(v & 32'h3, 32'h0);
        wr(`SFI_IDX_SELECT, 32'h0);
        // Mapped reads fill the buffer while the sink holds off
        wr(`SFI_IDX_CONFIG, 32'hC1);
        wr(`SFI_IDX_SELECT, 32'h1);
        wr(`SFI_IDX_WRITE, 32'h5A);
        rd(`SFI_IDX_FLAGS);
        chk_val(v & 32'hC, 32'h4);
        chk_pin(sel_n, 1'b1);
        for (k = 0; k < 8; k++) begin
            wr(`SFI_IDX_MAPADDR, {8'h0, a + 24'(4 * k)});
            idle;
            for (i = 0; i < 4; i++) q.push_back(fm(a + 24'(4 * k + i)));
        end
        // Drain with the sink stalling at random
        while (q.size() > 0) begin
            @(posedge sys_clk_in);
            if (m_valid === 1'b1 && map_ready_in === 1'b1)
                chk_val({24'h0, m_data}, {24'h0, q.pop_front()});
            map_ready_in <= (q.size() > 0) & 1'($random(seed));
        end
        // One more mapped read, popped through the data register
        wr(`SFI_IDX_MAPADDR, {8'h0, a});
        idle;
        for (k = 0; k < 5; k++) begin
            rd(`SFI_IDX_MAPDATA);
            chk_val(v & 32'h1FF, k < 4 ? {23'h1, fm(a + 24'(k))} : 32'h0);
        end
        // A disabled interface refuses a byte
        wr(`SFI_IDX_CONFIG, 32'h40);
        wr(`SFI_IDX_WRITE, 32'hA5);
        rd(`SFI_IDX_FLAGS);
        chk_val(v & 32'h8, 32'h0);
        settle;
        summarize;
    end
endmodule // tb
